// ==== rlsc_detect_interval.sv ====
module rlsc_detect_interval #(
  parameter int SHORT_CYCLES = rlsc_pkg::DETECT_SHORT_CYCLES,
  parameter int LONG_CYCLES  = rlsc_pkg::DETECT_LONG_CYCLES
) (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  // control
  input  wire logic       i_run,
  input  wire logic [1:0] i_period_sel,
  // result
  output logic            o_pulse
);

  localparam int unsigned W = rlsc_pkg::DETECT_CNT_W;
  localparam logic [W-1:0] SHORT_LAST = W'(SHORT_CYCLES - 1);
  localparam logic [W-1:0] LONG_LAST  = W'(LONG_CYCLES - 1);
  localparam logic [W-1:0] ONE        = W'(1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] last;
  logic         wrap;

  // reserved codes fall back to the short period
  assign last = (i_period_sel == rlsc_pkg::PERIOD_12MS) ? LONG_LAST : SHORT_LAST;
  // >= so a shortened period mid-count still fires
  assign wrap = i_run && (cnt_q >= last);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else if (!i_run || wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + ONE;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= wrap;
    end
  end

  AST_PERIOD_LENGTH: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_pulse |-> ($past(cnt_q) >= $past(last)) && cnt_q == '0)
    else $error("detect pulse off its period");

endmodule

// ==== rlsc_lfps_debounce.sv ====
module rlsc_lfps_debounce #(
  parameter int CYCLES = rlsc_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  // control
  input  wire logic i_armed,
  input  wire logic i_lfps,
  input  wire logic i_debounce_en,
  // result
  output logic      o_exit
);

  localparam int unsigned W = rlsc_pkg::DEBOUNCE_CNT_W;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  localparam logic [W-1:0] ONE  = W'(1);

  logic [W-1:0] cnt_q;
  logic         fired_q;
  logic         fire;

  // one exit per lfps burst; a dropout restarts the wait
  assign fire = i_armed && i_lfps && !fired_q && (!i_debounce_en || cnt_q == LAST);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else if (!i_armed || !i_lfps || fired_q) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + ONE;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fired_q <= 1'b0;
      o_exit  <= 1'b0;
    end else begin
      fired_q <= (fired_q || fire) && i_armed && i_lfps;
      o_exit  <= fire;
    end
  end

  AST_NO_DEBOUNCE_EXIT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_armed && i_lfps && !i_debounce_en && !fired_q) |=> o_exit)
    else $error("exit not raised one cycle after lfps without debounce");

  AST_DEBOUNCE_WAIT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (fire && i_debounce_en) |-> (cnt_q == LAST))
    else $error("debounced exit before full count");

endmodule

// ==== rlsc_link_ctrl.sv ====
module rlsc_link_ctrl #(
  parameter int DEBOUNCE_CYCLES     = rlsc_pkg::DEBOUNCE_CYCLES,
  parameter int DETECT_SHORT_CYCLES = rlsc_pkg::DETECT_SHORT_CYCLES,
  parameter int DETECT_LONG_CYCLES  = rlsc_pkg::DETECT_LONG_CYCLES
) (
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset_n,
  // register port
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic                 i_reg_wr_en,
  input  wire logic [7:0]           i_reg_wr_data,
  input  wire logic                 i_reg_rd_en,
  output logic [7:0]                o_reg_rd_data,
  output logic                      o_reg_rd_valid,
  // link state
  input  wire logic                 i_lfps_active,
  input  wire logic                 i_low_power_state,
  input  wire logic                 i_rx_detect_state,
  input  wire logic                 i_auto_compliance_enter,
  input  wire logic                 i_auto_compliance_exit,
  // equalization
  input  wire rlsc_pkg::rlsc_eq_type i_eq_level,
  output rlsc_pkg::rlsc_eq_type     o_eq_applied,
  // link actions
  output logic                      o_low_power_exit,
  output logic                      o_downstream_detect_pulse,
  output logic                      o_compliance_auto,
  output logic                      o_compliance_down,
  output logic                      o_compliance_up
);

  rlsc_pkg::rlsc_ctrl_type     ctrl_q;
  rlsc_pkg::rlsc_ctrl_type     wr_view;
  rlsc_pkg::rlsc_ctrl_type     rd_view;
  rlsc_pkg::rlsc_cm_state_type state_q;
  rlsc_pkg::rlsc_cm_state_type state_d;
  logic                        status_q;
  logic                        hit;
  logic                        detect_run;

  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == rlsc_pkg::LINK_CTRL_OFFSET);
  endfunction

  assign hit     = addr_hit(i_reg_addr);
  assign wr_view = rlsc_pkg::rlsc_ctrl_type'(i_reg_wr_data);

  // software fields; status bit never stored from a write
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= rlsc_pkg::rlsc_ctrl_type'(rlsc_pkg::LINK_CTRL_RESET);
    end else if (i_reg_wr_en && hit) begin
      ctrl_q                               <= wr_view;
      ctrl_q.compliance_status_flag        <= 1'b0;
    end
  end

  // read returns live status in place of the stored bit
  always_comb begin
    rd_view                        = ctrl_q;
    rd_view.compliance_status_flag = status_q;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rd_data  <= rlsc_pkg::READ_UNMAPPED;
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd_en;
      if (i_reg_rd_en) begin
        o_reg_rd_data <= hit ? 8'(rd_view) : rlsc_pkg::READ_UNMAPPED;
      end
    end
  end

  // compliance entry; forced codes take effect the cycle after the write
  always_comb begin
    state_d = state_q;
    unique case (ctrl_q.compliance_entry_select)
      rlsc_pkg::ENTRY_AUTO: begin
        if (state_q == rlsc_pkg::ST_AUTO) begin
          state_d = i_auto_compliance_exit ? rlsc_pkg::ST_OFF : rlsc_pkg::ST_AUTO;
        end else begin
          state_d = i_auto_compliance_enter ? rlsc_pkg::ST_AUTO : rlsc_pkg::ST_OFF;
        end
      end
      rlsc_pkg::ENTRY_DOWN: begin
        state_d = rlsc_pkg::ST_DOWN;
      end
      rlsc_pkg::ENTRY_UP: begin
        state_d = rlsc_pkg::ST_UP;
      end
      rlsc_pkg::ENTRY_NEVER: begin
        state_d = rlsc_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q           <= rlsc_pkg::ST_OFF;
      status_q          <= 1'b0;
      o_compliance_auto <= 1'b0;
      o_compliance_down <= 1'b0;
      o_compliance_up   <= 1'b0;
    end else begin
      state_q           <= state_d;
      status_q          <= (state_d != rlsc_pkg::ST_OFF);
      o_compliance_auto <= (state_d == rlsc_pkg::ST_AUTO);
      o_compliance_down <= (state_d == rlsc_pkg::ST_DOWN);
      o_compliance_up   <= (state_d == rlsc_pkg::ST_UP);
    end
  end

  // equalization steering
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_eq_applied <= '0;
    end else if (i_lfps_active && !ctrl_q.lowfreq_signal_equalize_en) begin
      o_eq_applied.first_downstream_eq_level  <= rlsc_pkg::EQ_ZERO;
      o_eq_applied.second_downstream_eq_level <= rlsc_pkg::EQ_ZERO;
      o_eq_applied.upstream_receiver_eq_level <= rlsc_pkg::EQ_ZERO;
    end else begin
      o_eq_applied <= i_eq_level;
    end
  end

  rlsc_lfps_debounce #(
    .CYCLES        (DEBOUNCE_CYCLES)
  ) u_debounce (
    .i_core_clk    (i_core_clk),
    .i_reset_n     (i_reset_n),
    .i_armed       (i_low_power_state),
    .i_lfps        (i_lfps_active),
    .i_debounce_en (ctrl_q.low_power_exit_debounce_en),
    .o_exit        (o_low_power_exit)
  );

  // detect runs in rx.detect, and in u2/u3 unless suppressed
  assign detect_run = i_rx_detect_state ||
                      (i_low_power_state && !ctrl_q.low_power_receiver_detect_off);

  rlsc_detect_interval #(
    .SHORT_CYCLES  (DETECT_SHORT_CYCLES),
    .LONG_CYCLES   (DETECT_LONG_CYCLES)
  ) u_detect (
    .i_core_clk    (i_core_clk),
    .i_reset_n     (i_reset_n),
    .i_run         (detect_run),
    .i_period_sel  (ctrl_q.downstream_detect_period),
    .o_pulse       (o_downstream_detect_pulse)
  );

  AST_STATUS_TRACKS_MODE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    status_q == (o_compliance_auto || o_compliance_down || o_compliance_up))
    else $error("status bit disagrees with compliance outputs");

  AST_LOWFREQ_SIGNAL_EQUALIZE_EN_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_lfps_active && !ctrl_q.lowfreq_signal_equalize_en) |=> (o_eq_applied == '0))
    else $error("equalization not zero during lfps");

  AST_LOWFREQ_SIGNAL_EQUALIZE_EN_KEPT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_lfps_active && ctrl_q.lowfreq_signal_equalize_en) |=> (o_eq_applied == $past(i_eq_level)))
    else $error("programmed equalization lost during lfps");

  AST_DETECT_OFF_IN_LOW_POWER: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (!detect_run ##1 !detect_run) |=> !o_downstream_detect_pulse)
    else $error("receiver detect pulse while suppressed");

  AST_AUTO_ENTER: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (ctrl_q.compliance_entry_select == rlsc_pkg::ENTRY_AUTO && i_auto_compliance_enter && !status_q)
    |=> status_q && o_compliance_auto)
    else $error("auto compliance entry missed");

  AST_FORCED_DOWN: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (ctrl_q.compliance_entry_select == rlsc_pkg::ENTRY_DOWN) |=> (o_compliance_down && !o_compliance_up))
    else $error("forced downstream compliance not applied");

  AST_FORCED_UP: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (ctrl_q.compliance_entry_select == rlsc_pkg::ENTRY_UP) |=> (o_compliance_up && !o_compliance_down))
    else $error("forced upstream compliance not applied");

  AST_NEVER_COMPLIANT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (ctrl_q.compliance_entry_select == rlsc_pkg::ENTRY_NEVER) |=> !status_q)
    else $error("compliance entered while disabled");

  AST_OTHER_ADDR_NO_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_reg_wr_en && !hit) |=> $stable(ctrl_q))
    else $error("write to another offset changed the register");

  AST_STATUS_READ_LIVE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_reg_rd_en && hit) |=> (o_reg_rd_valid && o_reg_rd_data[7] == $past(status_q)))
    else $error("status bit read back not from hardware");

endmodule

// ==== rlsc_link_partner.sv ====
module rlsc_link_partner (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  // requests from the bench
  input  wire logic       i_sleep,
  input  wire logic       i_lfps_go,
  input  wire logic [7:0] i_lfps_len,
  input  wire logic       i_rx_detect,
  // device reaction
  input  wire logic       i_exit_seen,
  // link state toward the device
  output logic            o_lfps_active,
  output logic            o_low_power_state,
  output logic            o_rx_detect_state
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       lp_q;
  logic       rxd_q;
  logic [7:0] burst_q;

  // the link stays asleep until the device itself asks to leave
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lp_q <= 1'b0;
    end else if (i_sleep) begin
      lp_q <= 1'b1;
    end else if (i_exit_seen) begin
      lp_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      burst_q <= 8'h00;
    end else if (i_lfps_go) begin
      burst_q <= i_lfps_len;
    end else if (burst_q != 8'h00) begin
      burst_q <= burst_q - 8'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rxd_q <= 1'b0;
    end else begin
      rxd_q <= i_rx_detect;
    end
  end

  assign o_lfps_active     = (burst_q != 8'h00);
  assign o_low_power_state = lp_q;
  assign o_rx_detect_state = rxd_q;
endmodule

// ==== rlsc_pkg.sv ====
package rlsc_pkg;

  // register map
  localparam logic [7:0] LINK_CTRL_OFFSET = 8'h22;
  localparam logic [7:0] LINK_CTRL_RESET  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // receiver-detect period codes
  localparam logic [1:0] PERIOD_8MS       = 2'h0;
  localparam logic [1:0] PERIOD_12MS      = 2'h1;

  // compliance entry codes
  localparam logic [1:0] ENTRY_AUTO       = 2'h0;
  localparam logic [1:0] ENTRY_DOWN       = 2'h1;
  localparam logic [1:0] ENTRY_UP         = 2'h2;
  localparam logic [1:0] ENTRY_NEVER      = 2'h3;

  localparam logic [3:0] EQ_ZERO          = 4'h0;

  // timing
  localparam int CLK_MHZ                  = 100;
  localparam int US_PER_MS                = 1000;
  localparam int DEBOUNCE_TIME_US         = 200;
  localparam int DETECT_SHORT_MS          = 8;
  localparam int DETECT_LONG_MS           = 12;
  localparam int DEBOUNCE_CYCLES          = DEBOUNCE_TIME_US * CLK_MHZ;
  localparam int DETECT_SHORT_CYCLES      = DETECT_SHORT_MS * US_PER_MS * CLK_MHZ;
  localparam int DETECT_LONG_CYCLES       = DETECT_LONG_MS * US_PER_MS * CLK_MHZ;
  localparam int DEBOUNCE_CNT_W           = 15;
  localparam int DETECT_CNT_W             = 21;

  typedef struct packed {
    logic       compliance_status_flag;
    logic       lowfreq_signal_equalize_en;
    logic       low_power_exit_debounce_en;
    logic       low_power_receiver_detect_off;
    logic [1:0] downstream_detect_period;
    logic [1:0] compliance_entry_select;
  } rlsc_ctrl_type;

  typedef struct packed {
    logic [3:0] first_downstream_eq_level;
    logic [3:0] second_downstream_eq_level;
    logic [3:0] upstream_receiver_eq_level;
  } rlsc_eq_type;

  typedef enum logic [1:0] {ST_OFF, ST_AUTO, ST_DOWN, ST_UP} rlsc_cm_state_type;

endpackage

// ==== tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DEB   = 20;
  localparam int SHORT = 40;
  localparam int LONG  = 60;

  logic                  clk    = 1'b0;
  logic                  rst_n  = 1'b0;
  logic [7:0]            addr   = 8'h00;
  logic                  wr     = 1'b0;
  logic [7:0]            wdata  = 8'h00;
  logic                  rd     = 1'b0;
  rlsc_pkg::rlsc_eq_type eq_lvl = '0;
  logic                  enter  = 1'b0;
  logic                  leave  = 1'b0;
  logic                  sleep  = 1'b0;
  logic                  go     = 1'b0;
  logic                  rxdet  = 1'b0;
  logic [7:0]            len    = 8'h00;
  logic [7:0]            rnd    = 8'h15;
  logic [7:0]            rdata;
  logic                  rvalid;
  rlsc_pkg::rlsc_eq_type eq_app;
  logic                  lfps;
  logic                  lp;
  logic                  rxd;
  logic                  lp_exit;
  logic                  det;
  logic                  c_auto;
  logic                  c_down;
  logic                  c_up;
  logic [7:0]            ctrl;
  logic [7:0]            d;
  int                    miscompares = 0;
  int                    num_checks = 0;
  int                    n;
  int                    t1;
  int                    t2;

  always #5 clk = ~clk;

  rlsc_link_ctrl #(.DEBOUNCE_CYCLES(DEB), .DETECT_SHORT_CYCLES(SHORT), .DETECT_LONG_CYCLES(LONG)) i_rlsc_link_ctrl (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr_en(wr), .i_reg_wr_data(wdata),
    .i_reg_rd_en(rd), .o_reg_rd_data(rdata), .o_reg_rd_valid(rvalid), .i_lfps_active(lfps),
    .i_low_power_state(lp), .i_rx_detect_state(rxd), .i_auto_compliance_enter(enter),
    .i_auto_compliance_exit(leave), .i_eq_level(eq_lvl), .o_eq_applied(eq_app), .o_low_power_exit(lp_exit),
    .o_downstream_detect_pulse(det), .o_compliance_auto(c_auto), .o_compliance_down(c_down),
    .o_compliance_up(c_up));

  rlsc_link_partner i_rlsc_link_partner (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_sleep(sleep), .i_lfps_go(go), .i_lfps_len(len),
    .i_rx_detect(rxdet), .i_exit_seen(lp_exit), .o_lfps_active(lfps), .o_low_power_state(lp),
    .o_rx_detect_state(rxd));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read valid", 12'h001, {11'h000, rvalid});
    v = rdata;
  endtask

  task automatic final_report;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    final_report;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(8'h22, d);
    chk("reset value", 12'h000, {4'h0, d});
    reg_rd(8'h23, d);
    chk("unmapped read", 12'h000, {4'h0, d});
    // first four passes sweep every entry code, the rest are random
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      ctrl = (i < 4) ? {rnd[7:2], i[1:0]} : rnd;
      reg_wr(8'h22, ctrl);
      reg_wr(8'h5A, ~ctrl);
      reg_rd(8'h22, d);
      chk("readback", {4'h0, ctrl[1:0] == 2'h1 || ctrl[1:0] == 2'h2, ctrl[6:0]}, {4'h0, d});
      chk("forced entry", {10'h000, ctrl[1:0] == rlsc_pkg::ENTRY_DOWN, ctrl[1:0] == rlsc_pkg::ENTRY_UP},
          {9'h000, c_auto, c_down, c_up});
    end
    for (int i = 0; i < 2; i++) begin
      ctrl = (i == 0) ? 8'h00 : 8'h03;
      reg_wr(8'h22, ctrl);
      @(posedge clk);
      enter <= 1'b1;
      @(posedge clk);
      enter <= 1'b0;
      #1;
      chk("auto entry", {11'h000, i == 0}, {11'h000, c_auto});
      reg_rd(8'h22, d);
      chk("status flag", {4'h0, i == 0, ctrl[6:0]}, {4'h0, d});
      @(posedge clk);
      leave <= 1'b1;
      @(posedge clk);
      leave <= 1'b0;
      #1;
      chk("auto exit", 12'h000, {11'h000, c_auto});
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      reg_wr(8'h22, {1'b0, i[0], 6'h03});
      eq_lvl <= {rnd, rnd[3:0] ^ 4'h5};
      len <= i[1] ? 8'h0C : 8'h00;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("eq applied", (i[1] && !i[0]) ? 12'h000 : eq_lvl, eq_app);
      repeat (12) @(posedge clk);
    end
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h22, {2'b00, i[1], 5'h13});
      sleep <= 1'b1;
      @(posedge clk);
      sleep <= 1'b0;
      len <= i[0] ? 8'(DEB + 10) : 8'(DEB / 2);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      t1 = 0;
      for (int k = 0; k < DEB + 30; k++) begin
        @(posedge clk);
        #1;
        if (lp_exit === 1'b1) begin
          n++;
          t1 = k;
        end
      end
      chk_cnt("exit pulses", (i[1] && !i[0]) ? 0 : 1, n);
      chk_cnt("exit delay", 1, int'(n == 0 || (t1 >= (i[1] ? DEB - 1 : 0) && t1 <= (i[1] ? DEB + 1 : 1))));
    end
    // rx detect runs first from the detect state, then from low power
    for (int c = 0; c < 5; c++) begin
      @(posedge clk);
      rxdet <= 1'b0;
      reg_wr(8'h22, {3'b000, c == 4, (c == 1) ? 2'h1 : (c == 2) ? 2'h2 : 2'h0, 2'h3});
      rxdet <= (c < 3);
      sleep <= (c == 3);
      n = 0;
      t1 = 0;
      t2 = 0;
      for (int k = 0; k < 160; k++) begin
        @(posedge clk);
        #1;
        if (det === 1'b1) begin
          n++;
          if (n == 1) t1 = k;
          if (n == 2) t2 = k;
        end
      end
      chk_cnt("detect period", (c == 4) ? 0 : (c == 1) ? LONG : SHORT, t2 - t1);
    end
    final_report;
  end
endmodule
